// File: fcs_pkg.sv
// Behaviour
// - Upper command bits select one of eight commands.
// - Head flag loads head; fifteen idle revolutions unload.
// - Rate bits choose step spacing; settle time is fixed.
// - Verify settles, waits head, matches ID track.
// - Track mismatch with good CRC flags seek error.
// - Bad ID CRC retries; four revolutions then stop.
// - Restore steps out to track zero, 255 max.
// - Reset release runs a restore automatically.
// - Seek steps toward data register value.
// - Step repeats last direction, optional track update.
// - Step-in goes inward, step-out goes outward.
// - Side-out variant keeps side during positioning.
// - Sector commands load head, optional settle.
// - Match track, sector, side, CRC within revolutions.
// - Length code maps 128 to 1024 bytes.
// - Multiple flag advances sector until search fails.
// - Side compare fails after five index pulses.
// - Variant length flag remaps codes; bit 1 drives side.
// - Write sector bit 0 picks normal or deleted mark.
// - Data mark must follow ID within 30/43 bytes.
// - Each byte raises request; unread byte sets lost.
// - Force interrupt bits choose the interrupt condition.
// - Read/write commands need drive ready to run.
package fcs_pkg;
	// Register byte offsets inside the 16-byte window.
	localparam logic [3:0] OFS_CMD = 4'h0;
	localparam logic [3:0] OFS_TRK = 4'h4;
	localparam logic [3:0] OFS_SEC = 4'h8;
	localparam logic [3:0] OFS_DAT = 4'hC;
	// Values after reset.
	localparam logic [7:0] TRK_RST = 8'h00;
	localparam logic [7:0] SEC_RST = 8'h01;
	localparam logic [7:0] CMD_RESTORE = 8'h00;
	// Command field positions.
	localparam int CB_R0 = 0;
	localparam int CB_F1 = 1;
	localparam int CB_V = 2;
	localparam int CB_H = 3;
	localparam int CB_U = 4;
	// Search and head unload limits in index pulses, and step limit.
	localparam logic [3:0] REV_SEARCH = 4'h4;
	localparam logic [3:0] REV_SIDE = 4'h5;
	localparam logic [3:0] REV_UNLOAD = 4'hF;
	localparam logic [7:0] MAX_STEPS = 8'hFF;
	// Byte windows after the ID field.
	localparam logic [10:0] DAM_SD = 11'h01E;
	localparam logic [10:0] DAM_DD = 11'h02B;
	localparam logic [10:0] WGAP_SD = 11'h00B;
	localparam logic [10:0] WGAP_DD = 11'h016;
	// Data address marks.
	localparam logic [7:0] MARK_NORMAL = 8'hFB;
	localparam logic [7:0] MARK_DELETED = 8'hF8;
	// Times in ms and their cycle counts at the clock rate.
	localparam int CLK_KHZ = 40000;
	localparam int SETTLE_MS = 15;
	localparam int STEP_MS0 = 3;
	localparam int STEP_MS1 = 6;
	localparam int STEP_MS2 = 10;
	localparam int STEP_MS3 = 15;
	localparam int SETTLE_CYC = SETTLE_MS * CLK_KHZ;
	localparam int STEP_CYC0 = STEP_MS0 * CLK_KHZ;
	localparam int STEP_CYC1 = STEP_MS1 * CLK_KHZ;
	localparam int STEP_CYC2 = STEP_MS2 * CLK_KHZ;
	localparam int STEP_CYC3 = STEP_MS3 * CLK_KHZ;
	// Sequencer states, one-hot.
	typedef enum logic [12:0] {
		S_IDLE = 13'h0001,
		S_START = 13'h0002,
		S_PLAN = 13'h0004,
		S_STEP = 13'h0008,
		S_SWAIT = 13'h0010,
		S_SETTLE = 13'h0020,
		S_HLT = 13'h0040,
		S_SEARCH = 13'h0080,
		S_DAM = 13'h0100,
		S_READ = 13'h0200,
		S_WGAP = 13'h0400,
		S_WRITE = 13'h0800,
		S_DONE = 13'h1000
	} fcs_state_type;
	// Bytes per sector from the ID length code and variant flags.
	function automatic logic [10:0] fcs_sec_bytes(input logic [1:0] code,
		input logic alt, input logic b);
		logic [1:0] c;
		c = (alt & ~b) ? code + 2'h1 : code;
		fcs_sec_bytes = 11'h080 << c;
	endfunction
endpackage

// File: fcs_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for drive pins; only stage two is read.
module fcs_sync #(
	parameter int W = 1
) (
	input wire logic clk, // Controller clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic ce, // Clock enable.
	input wire logic [W-1:0] d, // Asynchronous pin levels.
	output logic [W-1:0] q // Synchronised levels.
);
	logic [W-1:0] meta_r; // First stage, feeds only the second.

	// Both stages hold while the clock enable is low.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else if (ce) begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // fcs_sync

// File: fcs_delay.sv
`timescale 1ns/1ps
// Down-counter for step spacing and head settle delays.
module fcs_delay #(
	parameter int W = 20
) (
	input wire logic clk, // Controller clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic ce, // Clock enable.
	input wire logic load, // Start a new delay.
	input wire logic [W-1:0] load_val, // Delay length in cycles.
	output logic done // High once the count has run out.
);
	logic [W-1:0] cnt_r; // Remaining cycles.

	assign done = (cnt_r == '0);

	// Load wins over counting so a restart is never missed.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (ce) begin
			if (load) begin
				cnt_r <= load_val;
			end else if (!done) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule // fcs_delay

// File: fcs_top.sv
`timescale 1ns/1ps
// Floppy command sequencer with an AHB-Lite register slave.
module fcs_top #(
	parameter logic SIDE_OUT_VARIANT = 1'b0, // Side-out pin variant.
	parameter int SETTLE_CYC = fcs_pkg::SETTLE_CYC, // Head settle time.
	parameter int STEP_CYC0 = fcs_pkg::STEP_CYC0, // Step rate 00.
	parameter int STEP_CYC1 = fcs_pkg::STEP_CYC1, // Step rate 01.
	parameter int STEP_CYC2 = fcs_pkg::STEP_CYC2, // Step rate 10.
	parameter int STEP_CYC3 = fcs_pkg::STEP_CYC3 // Step rate 11.
) (
	input wire logic hclk, // Bus and controller clock.
	input wire logic hresetn, // Master reset, active low.
	input wire logic hce, // Clock enable, freezes all state.
	input wire logic hsel, // Slave select.
	input wire logic [31:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic [2:0] hsize, // Transfer size, word only.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready.
	output logic [31:0] hrdata, // Read data.
	output logic hreadyout, // Slave ready.
	output logic hresp, // Always OKAY.
	input wire logic index_sense, // Index pulse, active high.
	input wire logic track_zero_sense_n, // Track zero, active low.
	input wire logic drive_ready, // Drive ready.
	input wire logic head_settled_input, // Head engaged.
	input wire logic single_density, // High for single density.
	input wire logic id_strobe, // ID field assembled.
	input wire logic [7:0] id_track, // ID track number.
	input wire logic [7:0] id_side, // ID side number.
	input wire logic [7:0] id_sector, // ID sector number.
	input wire logic [1:0] id_len, // ID length code.
	input wire logic id_crc_ok, // ID CRC good.
	input wire logic dam_strobe, // Data mark found.
	input wire logic dam_deleted, // Data mark is deleted.
	input wire logic rx_strobe, // Data byte assembled.
	input wire logic [7:0] rx_byte, // Assembled byte.
	input wire logic crc_strobe, // Data field CRC checked.
	input wire logic crc_ok, // Data field CRC good.
	input wire logic byte_tick, // One byte time on disk.
	output logic step_pulse, // Step pulse.
	output logic step_dir_in, // Step direction, high inward.
	output logic head_engage_request, // Head load.
	output logic side_select_out, // Side select.
	output logic byte_request, // Byte request.
	output logic done_interrupt, // Completion interrupt.
	output logic write_gate, // Write gate.
	output logic tx_strobe, // Byte to write.
	output logic [7:0] tx_byte // Outgoing byte.
);
	import fcs_pkg::*;

	fcs_state_type state_r; // Sequencer state.
	logic [7:0] cmd_r; // Current command word.
	logic [7:0] trk_r; // Track register.
	logic [7:0] sec_r; // Sector register.
	logic [7:0] host_byte_reg; // Data register.
	logic busy_r, serr_r, crc_r, lost_r, rtype_r, type1_r; // Status.
	logic restore_pend_r; // Restore owed after reset.
	logic [7:0] steps_r; // Pulses in this command.
	logic [3:0] revs_r; // Index pulses during a search.
	logic [3:0] idle_revs_r; // Index pulses while idle.
	logic [10:0] bytes_r; // Byte counter.
	logic [1:0] len_r; // Length code of matched ID.
	logic [3:0] fi_cond_r; // Armed force interrupt conditions.
	logic idx_d_r, rdy_d_r; // Delayed pins for edges.
	logic tmr_ld_r; // Timer load strobe.
	logic [19:0] tmr_val_r; // Timer load value.
	logic tmr_done; // Timer expired.
	logic wpend_r; // Write data phase pending.
	logic [3:0] waddr_r; // Write register offset.
	logic [4:0] pin_s; // Synchronised drive pins.

	// Every drive pin crosses two flops before use.
	fcs_sync #(.W(5)) u_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.ce(hce),
		.d({index_sense, track_zero_sense_n, drive_ready,
			head_settled_input, single_density}),
		.q(pin_s)
	);

	// One timer serves step spacing and head settling.
	fcs_delay #(.W(20)) u_delay (
		.clk(hclk),
		.rst_n(hresetn),
		.ce(hce),
		.load(tmr_ld_r),
		.load_val(tmr_val_r),
		.done(tmr_done)
	);

	// Pin levels and edges.
	wire idx_s = pin_s[4];
	wire tr0_n_s = pin_s[3];
	wire rdy_s = pin_s[2];
	wire hlt_s = pin_s[1];
	wire sd_s = pin_s[0];
	wire idx_edge = idx_s & ~idx_d_r;
	wire rdy_rise = rdy_s & ~rdy_d_r;
	wire rdy_fall = ~rdy_s & rdy_d_r;

	// Bus decode; the window is 16 bytes at the base of the slot.
	wire ahb_go = hsel & htrans[1] & hready;
	wire in_map = (haddr[31:4] == 28'h0000000);
	wire rd_go = ahb_go & ~hwrite & in_map;
	wire rd_stat = rd_go & (haddr[3:0] == OFS_CMD);
	wire rd_dat = rd_go & (haddr[3:0] == OFS_DAT);
	wire wr_cmd = wpend_r & (waddr_r == OFS_CMD);
	wire wr_trk = wpend_r & (waddr_r == OFS_TRK);
	wire wr_sec = wpend_r & (waddr_r == OFS_SEC);
	wire wr_dat = wpend_r & (waddr_r == OFS_DAT);
	wire [7:0] nc = hwdata[7:0];

	// Command classes; type III shares the 11 prefix.
	wire nc_force = (nc[7:4] == 4'hD);
	wire op_restore = (cmd_r[7:4] == 4'h0);
	wire op_seek = (cmd_r[7:4] == 4'h1);
	wire op_step = (cmd_r[7:5] == 3'h1);
	wire op_in = (cmd_r[7:5] == 3'h2);
	wire op_out = (cmd_r[7:5] == 3'h3);
	wire op_rd = (cmd_r[7:5] == 3'h4);
	wire op_wr = (cmd_r[7:5] == 3'h5);
	wire op_t2 = op_rd | op_wr;
	wire vfy = cmd_r[CB_V];
	wire multi = cmd_r[CB_U];

	// Ignoring new commands while busy protects a running one.
	wire accept = wr_cmd & ~busy_r & ~nc_force;

	// Status shows type I or type II layout.
	wire [7:0] stat_v = type1_r ?
		{~rdy_s, 1'b0, head_engage_request & hlt_s, serr_r, crc_r,
		~tr0_n_s, idx_s, busy_r} :
		{~rdy_s, 1'b0, rtype_r, serr_r, crc_r, lost_r, byte_request,
		busy_r};

	// Read mux; unmapped reads return zero.
	wire [7:0] rd_v = !in_map ? 8'h00 :
		(haddr[3:0] == OFS_CMD) ? stat_v :
		(haddr[3:0] == OFS_TRK) ? trk_r :
		(haddr[3:0] == OFS_SEC) ? sec_r :
		(haddr[3:0] == OFS_DAT) ? host_byte_reg : 8'h00;

	// Step rate selection.
	wire [19:0] rate_cyc = (cmd_r[1:0] == 2'h0) ? 20'(STEP_CYC0) :
		(cmd_r[1:0] == 2'h1) ? 20'(STEP_CYC1) :
		(cmd_r[1:0] == 2'h2) ? 20'(STEP_CYC2) : 20'(STEP_CYC3);

	// Positioning plan: finished, failed, and next direction.
	wire plan_end = op_restore ? ~tr0_n_s :
		op_seek ? (trk_r == host_byte_reg) : (steps_r != 8'h00);
	wire plan_fail = op_restore & tr0_n_s & (steps_r == MAX_STEPS);
	wire dir_nxt = op_seek ? (host_byte_reg > trk_r) :
		op_in ? 1'b1 : (op_out | op_restore) ? 1'b0 :
		step_dir_in;
	wire trk_upd = op_seek | (cmd_r[CB_U] & (op_step | op_in | op_out));

	// ID comparison for sector commands.
	wire side_cmp = ~SIDE_OUT_VARIANT & cmd_r[CB_F1];
	wire side_ok = ~side_cmp | (id_side[0] == cmd_r[CB_H]);
	wire id_hit = (id_track == trk_r) & (id_sector == sec_r) & side_ok;
	wire [3:0] rev_lim = (~type1_r & side_cmp) ? REV_SIDE : REV_SEARCH;
	wire [10:0] dam_lim = sd_s ? DAM_SD : DAM_DD;
	wire [10:0] gap_lim = sd_s ? WGAP_SD : WGAP_DD;
	wire [10:0] sec_bytes = fcs_sec_bytes(len_r, SIDE_OUT_VARIANT,
		cmd_r[CB_H]);

	// Bus slave: zero wait states, registered read data, always OKAY.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wpend_r <= 1'b0;
			waddr_r <= 4'h0;
		end else if (hce) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wpend_r <= ahb_go & hwrite & in_map;
			waddr_r <= haddr[3:0];
			if (rd_go) begin
				hrdata <= {24'h000000, rd_v};
			end
		end
	end

	// Pin history for edge detection.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_d_r <= 1'b0;
			rdy_d_r <= 1'b0;
		end else if (hce) begin
			idx_d_r <= idx_s;
			rdy_d_r <= rdy_s;
		end
	end

	// Byte request and interrupt: clears first, so events win.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			byte_request <= 1'b0;
			done_interrupt <= 1'b0;
			fi_cond_r <= 4'h0;
		end else if (hce) begin
			if (rd_dat | wr_dat) begin
				byte_request <= 1'b0;
			end
			if (rd_stat | wr_cmd) begin
				done_interrupt <= 1'b0;
			end
			if (accept) begin
				fi_cond_r <= 4'h0;
			end
			if (wr_cmd & nc_force) begin
				fi_cond_r <= nc[3:0];
				if (nc[3]) begin
					done_interrupt <= 1'b1;
				end
			end
			if ((fi_cond_r[0] & rdy_rise) | (fi_cond_r[1] & rdy_fall) |
				(fi_cond_r[2] & idx_edge)) begin
				done_interrupt <= 1'b1;
			end
			if (state_r == S_DONE) begin
				done_interrupt <= 1'b1;
			end
			if (((state_r == S_READ) & rx_strobe & (bytes_r != 11'h000))
				| ((state_r == S_SEARCH) & op_wr & id_strobe &
				id_hit & id_crc_ok) | ((state_r == S_WRITE) &
				byte_tick & (bytes_r > 11'h001))) begin
				byte_request <= 1'b1;
			end
		end
	end

	// Head unload after idle revolutions.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_revs_r <= 4'h0;
		end else if (hce) begin
			if (busy_r) begin
				idle_revs_r <= 4'h0;
			end else if (idx_edge & (idle_revs_r != REV_UNLOAD)) begin
				idle_revs_r <= idle_revs_r + 4'h1;
			end
		end
	end

	// Command sequencer.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= S_IDLE;
			cmd_r <= CMD_RESTORE;
			trk_r <= TRK_RST;
			sec_r <= SEC_RST;
			host_byte_reg <= 8'h00;
			{busy_r, serr_r, crc_r, lost_r, rtype_r} <= 5'h00;
			type1_r <= 1'b1;
			restore_pend_r <= 1'b1;
			steps_r <= 8'h00;
			revs_r <= 4'h0;
			bytes_r <= 11'h000;
			len_r <= 2'h0;
			tmr_ld_r <= 1'b0;
			tmr_val_r <= 20'h00000;
			step_pulse <= 1'b0;
			step_dir_in <= 1'b0;
			head_engage_request <= 1'b0;
			side_select_out <= 1'b0;
			write_gate <= 1'b0;
			tx_strobe <= 1'b0;
			tx_byte <= 8'h00;
		end else if (hce) begin
			tmr_ld_r <= 1'b0;
			tx_strobe <= 1'b0;
			step_pulse <= 1'b0;
			// Host writes to plain registers.
			if (wr_trk) begin
				trk_r <= nc;
			end
			if (wr_sec) begin
				sec_r <= nc;
			end
			if (wr_dat) begin
				host_byte_reg <= nc;
			end
			if (idx_edge) begin
				revs_r <= revs_r + 4'h1;
			end
			if (~busy_r & (idle_revs_r == REV_UNLOAD)) begin
				head_engage_request <= 1'b0;
			end
			case (state_r)
				S_IDLE: begin
					// Reset release owes one restore.
					if (restore_pend_r | accept) begin
						cmd_r <= restore_pend_r ? CMD_RESTORE : nc;
						restore_pend_r <= 1'b0;
						busy_r <= 1'b1;
						{serr_r, crc_r, lost_r, rtype_r} <= 4'h0;
						state_r <= S_START;
					end
				end
				S_START: begin
					steps_r <= 8'h00;
					type1_r <= ~cmd_r[7];
					if (~cmd_r[7]) begin
						head_engage_request <= cmd_r[CB_H];
						state_r <= S_PLAN;
					end else if (~rdy_s | ~op_t2) begin
						state_r <= S_DONE;
					end else begin
						head_engage_request <= 1'b1;
						if (SIDE_OUT_VARIANT) begin
							side_select_out <= cmd_r[CB_F1];
						end
						tmr_ld_r <= cmd_r[CB_V];
						tmr_val_r <= 20'(SETTLE_CYC);
						state_r <= cmd_r[CB_V] ? S_SETTLE : S_HLT;
					end
				end
				S_PLAN: begin
					if (plan_fail) begin
						serr_r <= 1'b1;
						state_r <= S_DONE;
					end else if (plan_end) begin
						if (op_restore) begin
							trk_r <= 8'h00;
						end
						if (vfy) begin
							head_engage_request <= 1'b1;
							tmr_ld_r <= 1'b1;
							tmr_val_r <= 20'(SETTLE_CYC);
						end
						state_r <= vfy ? S_SETTLE : S_DONE;
					end else begin
						step_dir_in <= dir_nxt;
						state_r <= S_STEP;
					end
				end
				S_STEP: begin
					// One pulse, then the rate delay.
					step_pulse <= 1'b1;
					steps_r <= steps_r + 8'h01;
					if (trk_upd) begin
						trk_r <= step_dir_in ? trk_r + 8'h01 :
							trk_r - 8'h01;
					end
					tmr_ld_r <= 1'b1;
					tmr_val_r <= rate_cyc;
					state_r <= S_SWAIT;
				end
				S_SWAIT: begin
					if (tmr_done & ~tmr_ld_r) begin
						state_r <= S_PLAN;
					end
				end
				S_SETTLE: begin
					if (tmr_done & ~tmr_ld_r) begin
						state_r <= S_HLT;
					end
				end
				S_HLT: begin
					if (hlt_s) begin
						revs_r <= 4'h0;
						state_r <= S_SEARCH;
					end
				end
				S_SEARCH: begin
					if (revs_r == rev_lim) begin
						serr_r <= 1'b1;
						state_r <= S_DONE;
					end else if (id_strobe & type1_r) begin
						if (id_crc_ok) begin
							serr_r <= (id_track != trk_r);
							state_r <= S_DONE;
						end else if (id_track == trk_r) begin
							crc_r <= 1'b1;
						end
					end else if (id_strobe & id_hit) begin
						if (id_crc_ok) begin
							len_r <= id_len;
							bytes_r <= 11'h000;
							state_r <= op_rd ? S_DAM : S_WGAP;
						end else begin
							crc_r <= 1'b1;
						end
					end
				end
				S_DAM: begin
					if (dam_strobe) begin
						rtype_r <= dam_deleted;
						bytes_r <= sec_bytes;
						state_r <= S_READ;
					end else if (byte_tick) begin
						bytes_r <= bytes_r + 11'h001;
						if (bytes_r + 11'h001 >= dam_lim) begin
							serr_r <= 1'b1;
							state_r <= S_DONE;
						end
					end
				end
				S_READ: begin
					if (rx_strobe & (bytes_r != 11'h000)) begin
						host_byte_reg <= rx_byte;
						lost_r <= lost_r | byte_request;
						bytes_r <= bytes_r - 11'h001;
					end else if (crc_strobe & (bytes_r == 11'h000)) begin
						if (~crc_ok) begin
							crc_r <= 1'b1;
							state_r <= S_DONE;
						end else if (multi) begin
							sec_r <= sec_r + 8'h01;
							revs_r <= 4'h0;
							state_r <= S_SEARCH;
						end else begin
							state_r <= S_DONE;
						end
					end
				end
				S_WGAP: begin
					if (byte_tick) begin
						bytes_r <= bytes_r + 11'h001;
						if (bytes_r + 11'h001 >= gap_lim) begin
							if (byte_request) begin
								lost_r <= 1'b1;
								state_r <= S_DONE;
							end else begin
								write_gate <= 1'b1;
								tx_strobe <= 1'b1;
								tx_byte <= cmd_r[CB_R0] ? MARK_DELETED :
									MARK_NORMAL;
								bytes_r <= sec_bytes;
								state_r <= S_WRITE;
							end
						end
					end
				end
				S_WRITE: begin
					if (byte_tick & (bytes_r != 11'h000)) begin
						tx_strobe <= 1'b1;
						tx_byte <= byte_request ? 8'h00 : host_byte_reg;
						lost_r <= lost_r | byte_request;
						bytes_r <= bytes_r - 11'h001;
					end else if (byte_tick) begin
						write_gate <= 1'b0;
						if (multi) begin
							sec_r <= sec_r + 8'h01;
							revs_r <= 4'h0;
							state_r <= S_SEARCH;
						end else begin
							state_r <= S_DONE;
						end
					end
				end
				S_DONE: begin
					busy_r <= 1'b0;
					write_gate <= 1'b0;
					state_r <= S_IDLE;
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
			// Force interrupt ends any command at once.
			if (wr_cmd & nc_force) begin
				busy_r <= 1'b0;
				write_gate <= 1'b0;
				if (~busy_r) begin
					type1_r <= 1'b1;
				end
				state_r <= S_IDLE;
			end
		end
	end
endmodule // fcs_top

// File: fcs_monitor.sv
`timescale 1ns/1ps
// Watches the bus and drive pins of the sequencer from outside.
module fcs_monitor (
	input wire logic hclk, // Clock.
	input wire logic hresetn, // Reset, active low.
	input wire logic hsel, // Slave select.
	input wire logic [31:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready.
	input wire logic hreadyout, // Slave ready.
	input wire logic hresp, // Response.
	input wire logic rx_strobe, // Byte assembled.
	input wire logic step_pulse, // Step pulse.
	input wire logic step_dir_in, // Step direction.
	input wire logic head_engage_request, // Head load.
	input wire logic byte_request, // Byte request.
	input wire logic done_interrupt // Completion interrupt.
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic cmd_r; // Command write in its data phase.
	wire ap = hsel && htrans[1] && hready; // Address phase taken.
	// Remember a command write so its data can be judged next cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) cmd_r <= 1'b0;
		else cmd_r <= ap && hwrite && haddr == 32'h0;
	end
	property p_bus;
		hreadyout && !hresp;
	endproperty
	a_bus: assert property (p_bus) else $error("bus stalled or errored");
	property p_space;
		step_pulse |=> !step_pulse [*3];
	endproperty
	a_space: assert property (p_space) else $error("steps too close");
	property p_hon;
		cmd_r && !hwdata[7] && hwdata[3] |-> ##[1:4] head_engage_request;
	endproperty
	a_hon: assert property (p_hon) else $error("head not loaded");
	property p_hoff;
		cmd_r && !hwdata[7] && hwdata[3:2] == 2'h0 |-> ##[1:4] !head_engage_request;
	endproperty
	a_hoff: assert property (p_hoff) else $error("head not unloaded");
	property p_in;
		cmd_r && hwdata[7:5] == 3'h2 |-> ##[1:8] step_pulse && step_dir_in;
	endproperty
	a_in: assert property (p_in) else $error("no inward step");
	property p_out;
		cmd_r && hwdata[7:5] == 3'h3 |-> ##[1:8] step_pulse && !step_dir_in;
	endproperty
	a_out: assert property (p_out) else $error("no outward step");
	property p_iclr;
		ap && !hwrite && haddr == 32'h0 |=> !done_interrupt;
	endproperty
	a_iclr: assert property (p_iclr) else $error("interrupt kept");
	property p_rclr;
		ap && !hwrite && haddr == 32'hC && !rx_strobe |=> !byte_request;
	endproperty
	a_rclr: assert property (p_rclr) else $error("request kept");
endmodule // fcs_monitor
bind fcs_top fcs_monitor fcs_monitor_inst (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .rx_strobe,
	.step_pulse, .step_dir_in, .head_engage_request, .byte_request,
	.done_interrupt);

// File: fcs_drive_model.sv
`timescale 1ns/1ps
// Drive model: head position, track zero, index and head engage.
module fcs_drive_model (
	input wire logic hclk, // Clock.
	input wire logic step_pulse, // Step request.
	input wire logic step_dir_in, // High steps inward.
	input wire logic head_engage_request, // Head load.
	output logic track_zero_sense_n, // Low at track zero.
	output logic head_settled_input = 1'b0, // Head engaged.
	output logic index_sense = 1'b0 // Index pulse.
);
	logic [7:0] cyl = 8'h03; // Starts off track zero so restore steps.
	int ph = 0; // Rotation phase; one turn is 500 cycles.
	assign track_zero_sense_n = cyl != 8'h00;
	// The head engages one cycle after the load request.
	always @(posedge hclk) begin
		if (step_pulse) cyl <= step_dir_in ? cyl + 8'h01 : cyl - 8'h01;
		ph <= (ph == 499) ? 0 : ph + 1;
		index_sense <= ph == 0;
		head_settled_input <= head_engage_request;
	end
endmodule // fcs_drive_model

// File: floppy_command_sequencer_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the floppy command sequencer.
module floppy_command_sequencer_tb_top;
	import fcs_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0, id_len = 2'h0;
	logic [7:0] id_track = 8'h0, id_side = 8'h0, id_sector = 8'h0;
	logic [7:0] rx_byte = 8'h0, tx_byte;
	logic drive_ready = 1'b1, id_strobe = 1'b0, id_crc_ok = 1'b0;
	logic single_density = 1'b0, byte_tick = 1'b0;
	logic dam_strobe = 1'b0, rx_strobe = 1'b0, crc_strobe = 1'b0;
	logic crc_ok = 1'b0, hreadyout, hresp, step_pulse, step_dir_in;
	logic head_engage_request, side_select_out, byte_request;
	logic done_interrupt, write_gate, tx_strobe, index_sense;
	logic track_zero_sense_n, head_settled_input;
	int num_errors = 0, tests_run = 0;
	// Short delays keep stepping runs brief.
	fcs_top #(.SETTLE_CYC(20), .STEP_CYC0(4), .STEP_CYC1(6), .STEP_CYC2(8),
		.STEP_CYC3(10)) fcs_top_inst (.hready(hreadyout), .hce(1'b1),
		.hsize(3'h2), .dam_deleted(1'b0), .*);
	fcs_drive_model fcs_drive_model_inst (.*);
	initial forever #12.5 hclk = ~hclk;
	task chk(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One single AHB transfer; rd is taken at the data phase edge.
	task bus(input logic w, input logic [31:0] a, d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// Waits at least one edge, so a stale interrupt is never taken.
	task wint;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (done_interrupt !== 1'b1 && n < 4000);
		chk(done_interrupt, 1'b1);
	endtask
	// Twenty idle cycles, then one ID field strobe.
	task idf;
		repeat (20) @(posedge hclk);
		id_strobe <= 1'b1;
		@(posedge hclk) id_strobe <= 1'b0;
	endtask
	// One disk byte time, seen by the design for one cycle.
	task tick;
		byte_tick <= 1'b1;
		@(posedge hclk) byte_tick <= 1'b0;
		@(posedge hclk);
	endtask
	// Positioning command, then track register and head position.
	task pos(input logic [7:0] c, t);
		bus(1'b1, 32'h0, {24'h0, c});
		wint;
		bus(1'b0, 32'h4, 32'h0);
		chk(rd, {24'h0, t});
		chk(fcs_drive_model_inst.cyl, t);
		bus(1'b0, 32'h0, 32'h0);
		chk(rd[0], 1'b0);
	endtask
	task t_pos;
		wint;
		pos(8'h00, 8'h00);
		pos(8'h5B, 8'h01);
		chk(head_engage_request, 1'b1);
		pos(8'h3B, 8'h02);
		pos(8'h70, 8'h01);
		chk(head_engage_request, 1'b0);
		bus(1'b1, 32'hC, 32'h5);
		pos(8'h12, 8'h05);
	endtask
	task t_notready;
		drive_ready <= 1'b0;
		bus(1'b1, 32'h0, 32'h80);
		wint;
		bus(1'b0, 32'h0, 32'h0);
		chk(rd[7:0], 8'h80);
		drive_ready <= 1'b1;
	endtask
	task t_force;
		bus(1'b1, 32'h0, 32'hD4);
		wint;
		bus(1'b0, 32'h0, 32'h0);
		bus(1'b1, 32'h0, 32'hD8);
		wint;
		bus(1'b0, 32'h0, 32'h0);
		bus(1'b1, 32'h0, 32'hD0);
		repeat (20) @(posedge hclk);
		chk(done_interrupt, 1'b0);
	endtask
	// One 128-byte sector, each byte fetched by the host in time.
	task t_read;
		id_track <= 8'h05;
		id_sector <= 8'h01;
		id_crc_ok <= 1'b1;
		bus(1'b1, 32'h0, 32'h80);
		idf;
		repeat (3) @(posedge hclk);
		dam_strobe <= 1'b1;
		@(posedge hclk) dam_strobe <= 1'b0;
		for (int i = 0; i < 128; i++) begin
			@(posedge hclk);
			rx_byte <= 8'(i + 7);
			rx_strobe <= 1'b1;
			@(posedge hclk) rx_strobe <= 1'b0;
			repeat (2) @(posedge hclk);
			chk(byte_request, 1'b1);
			bus(1'b0, 32'hC, 32'h0);
			chk(rd, 32'(i + 7));
		end
		chk(byte_request, 1'b0);
		crc_ok <= 1'b1;
		crc_strobe <= 1'b1;
		@(posedge hclk) crc_strobe <= 1'b0;
		wint;
		bus(1'b0, 32'h0, 32'h0);
		chk(rd[4:0], 5'h0);
		bus(1'b1, 32'h0, 32'h80);
		wint;
		bus(1'b0, 32'h0, 32'h0);
		chk(rd[4], 1'b1);
	endtask
	// Single density: no data mark within 30 byte times.
	task t_dam;
		single_density <= 1'b1;
		bus(1'b1, 32'h0, 32'h80);
		idf;
		repeat (29) tick;
		repeat (3) @(posedge hclk);
		chk(done_interrupt, 1'b0);
		tick;
		wint;
		bus(1'b0, 32'h0, 32'h0);
		chk(rd[4], 1'b1);
		single_density <= 1'b0;
	endtask
	// Deleted-mark sector write: first byte served, the rest lost.
	task t_write;
		bus(1'b1, 32'h0, 32'hA1);
		idf;
		@(posedge hclk);
		chk(byte_request, 1'b1);
		bus(1'b1, 32'hC, 32'h3C);
		repeat (22) tick;
		chk(write_gate, 1'b1);
		chk(tx_strobe, 1'b1);
		chk(tx_byte, 8'hF8);
		tick;
		chk(tx_byte, 8'h3C);
		repeat (128) tick;
		chk(tx_byte, 8'h00);
		wint;
		chk(write_gate, 1'b0);
		chk(side_select_out, 1'b0);
		bus(1'b0, 32'h0, 32'h0);
		chk(rd[2], 1'b1);
		repeat (6900) @(posedge hclk);
		chk(head_engage_request, 1'b1);
		repeat (700) @(posedge hclk);
		chk(head_engage_request, 1'b0);
	endtask
	task end_sim;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_pos;
		t_notready;
		t_force;
		t_read;
		t_dam;
		t_write;
		end_sim;
	end
	// Cuts a hang short after about 80000 cycles.
	initial begin
		#2000000;
		num_errors++;
		end_sim;
	end
endmodule // floppy_command_sequencer_tb_top
